// [pkg/door_pkg.sv]
// Shared constants, register map and carrier types for the door access controller.
package door_pkg;
   localparam int unsigned CLK_HZ = 200000000;
   localparam int unsigned LINK_MIN_BPS = 1000000;
   localparam logic [15:0] LINK_BIT_CYCLES = 16'(CLK_HZ / LINK_MIN_BPS);
   localparam int unsigned NUM_PORTS = 10;
   localparam int unsigned MAX_DEVICES = 80;
   localparam logic [15:0] WIEGAND_MAX_BITS = 16'hFFFF;
   localparam int unsigned REKEY_HOURS = 30;
   localparam int unsigned NUM_RELAYS = 4;
   localparam int unsigned NUM_SCHED = 4;
   // Register map, word addresses on the plain port.
   localparam logic [7:0] REG_TICK_DIV = 8'h00;
   localparam logic [7:0] REG_UNLOCK = 8'h01;
   localparam logic [7:0] REG_EXT_UNLOCK = 8'h02;
   localparam logic [7:0] REG_HELD = 8'h03;
   localparam logic [7:0] REG_RESECURE = 8'h04;
   localparam logic [7:0] REG_PULSE = 8'h05;
   localparam logic [7:0] REG_RELAY_MODE = 8'h06;
   localparam logic [7:0] REG_CTRL = 8'h07;
   localparam logic [7:0] REG_PENDING = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h09;
   localparam logic [7:0] REG_SERIAL = 8'h0A;
   localparam logic [7:0] REG_WIEGAND_LEN = 8'h0B;
   localparam logic [7:0] REG_REKEY = 8'h0C;
   // Reset values.
   localparam logic [15:0] TICK_DIV_RST = 16'h00C8;
   localparam logic [15:0] UNLOCK_RST = 16'h0005;
   localparam logic [15:0] EXT_UNLOCK_RST = 16'h000F;
   localparam logic [15:0] HELD_RST = 16'h001E;
   localparam logic [15:0] RESECURE_RST = 16'h000A;
   localparam logic [15:0] PULSE_RST = 16'h0003;
   localparam logic [15:0] WIEGAND_LEN_RST = 16'h001A;
   localparam logic [15:0] REKEY_RST = 16'h0100;
   // Control bits.
   localparam int unsigned CTRL_SUPPRESS = 0;
   localparam int unsigned CTRL_LOCKDOWN_SW = 1;
   localparam int unsigned CTRL_SCHED_LSB = 8;
   localparam int unsigned CTRL_TRIG_LSB = 16;
   // Pending flag positions.
   localparam int unsigned PEND_EVENT = 0;
   localparam int unsigned PEND_FORCED = 1;
   localparam int unsigned PEND_HELD = 2;
   localparam int unsigned PEND_LINK_CRC = 3;
   localparam int unsigned PEND_BIO_LOSS = 4;
   localparam int unsigned PEND_SUBST = 5;
   localparam int unsigned PEND_NEW_SERIAL = 6;
   localparam int unsigned PEND_REKEY = 7;
   localparam int unsigned PEND_TAMPER = 8;
   localparam int unsigned PEND_DENIED = 9;
   localparam int unsigned PEND_W = 16;
   // Relay modes.
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_LATCH = 2'h1;
   localparam logic [1:0] MODE_PULSE = 2'h2;
   localparam logic [1:0] MODE_FOLLOW = 2'h3;
   // Supervised input classes.
   localparam logic [1:0] SUP_NORMAL = 2'h0;
   localparam logic [1:0] SUP_ALARM = 2'h1;
   localparam logic [1:0] SUP_OPEN = 2'h2;
   localparam logic [1:0] SUP_SHORT = 2'h3;
   // Event record source codes.
   localparam logic [3:0] EV_CARD = 4'h1;
   localparam logic [3:0] EV_EXIT_BTN = 4'h2;
   localparam logic [3:0] EV_BREAK_GLASS = 4'h3;
   localparam logic [3:0] EV_DENIED = 4'h4;

   typedef struct packed {
      logic valid;
      logic extended;
      logic [7:0] zone;
   } grant_req_t;

   typedef struct packed {
      logic valid;
      logic [3:0] source;
      logic [7:0] zone;
   } event_rec_t;

   typedef struct packed {
      logic valid;
      logic crc_ok;
      logic [3:0] port;
      logic [31:0] serial;
   } link_msg_t;

   typedef enum logic [3:0] {
      ST_LOCKED = 4'b0001,
      ST_RELEASED = 4'b0010,
      ST_OPEN = 4'b0100,
      ST_HELD = 4'b1000
   } door_state_t;
endpackage

// [design/door_access_controller.sv]
// Door access controller: lock release, door supervision, alarm relays, link supervision.
`timescale 1ns/10ps
`default_nettype none
module door_access_controller (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   input wire door_pkg::grant_req_t card_grant_i,
   input wire logic exit_push_button_i,
   input wire logic break_glass_unit_i,
   input wire logic door_open_i,
   input wire logic door_unlocked_i,
   input wire logic leaf2_open_i,
   input wire logic leaf2_unlocked_i,
   input wire logic [7:0] door_zone_i,
   input wire logic [1:0] sup_level_i,
   input wire logic [3:0] alarm_in_i,
   input wire logic [3:0] sched_active_i,
   input wire door_pkg::link_msg_t link_msg_i,
   input wire logic bio_link_up_i,
   input wire logic wiegand_done_i,
   input wire logic [15:0] wiegand_count_i,
   output logic lock_release_o,
   output logic [3:0] relay_o,
   output logic [3:0] sched_relay_o,
   output door_pkg::event_rec_t event_o,
   output logic wiegand_ok_o,
   output logic [1:0] sup_class_o
);
   logic [15:0] tick_div;
   logic [15:0] unlock_t;
   logic [15:0] ext_unlock_t;
   logic [15:0] held_t;
   logic [15:0] resecure_t;
   logic [15:0] pulse_t;
   logic [7:0] relay_mode;
   logic [31:0] ctrl;
   logic [15:0] pending;
   logic [31:0] serial_bound;
   logic serial_known;
   logic [15:0] wiegand_len;
   logic [15:0] rekey_t;
   logic [15:0] div_cnt;
   logic tick;
   door_pkg::door_state_t state;
   door_pkg::door_state_t next_state;
   logic [15:0] door_cnt;
   logic [15:0] rekey_cnt;
   wire [3:0] relay_q;
   logic [3:0] alarm_q;
   logic bio_q;
   localparam int NUM_RELAYS_L = door_pkg::NUM_RELAYS;

   // Address decode.
   wire wr_pend = wr_i && (addr_i == door_pkg::REG_PENDING);
   wire [15:0] ack_mask = wr_pend ? wdata_i[15:0] : 16'h0000;

   // Combined leaf inputs.
   wire any_open = door_open_i | leaf2_open_i;
   wire any_unlocked = door_unlocked_i | leaf2_unlocked_i;

   // Zone lockdown: a software switch or any selected pending event.
   wire [7:0] trig_sel = ctrl[door_pkg::CTRL_TRIG_LSB +: 8];
   wire lockdown = ctrl[door_pkg::CTRL_LOCKDOWN_SW] || ((pending[7:0] & trig_sel) != 8'h00);
   wire zone_match = (card_grant_i.zone == door_zone_i);
   wire card_ok = card_grant_i.valid && zone_match && !lockdown;
   wire card_denied = card_grant_i.valid && !card_ok;
   wire request = card_ok || exit_push_button_i || break_glass_unit_i;
   wire extended = card_ok && card_grant_i.extended;
   wire suppress = ctrl[door_pkg::CTRL_SUPPRESS];

   wire released = (state == door_pkg::ST_RELEASED) || (state == door_pkg::ST_OPEN);
   wire forced = (state == door_pkg::ST_LOCKED) && (any_open || any_unlocked) && !lock_release_o;
   wire cnt_zero = (door_cnt == 16'h0000);
   wire held_alarm = (state == door_pkg::ST_HELD) && tick && cnt_zero;

   // Link supervision.
   // A message naming a port beyond the supported count is flagged as a link error, like a failed CRC.
   wire port_ok = ({28'h0000000, link_msg_i.port} < door_pkg::NUM_PORTS);
   wire link_bad = link_msg_i.valid && !(link_msg_i.crc_ok && port_ok);
   wire link_good = link_msg_i.valid && link_msg_i.crc_ok && port_ok;
   wire new_serial = link_good && !serial_known;
   wire subst = link_good && serial_known && (link_msg_i.serial != serial_bound);
   wire bio_loss = bio_q && !bio_link_up_i;
   wire rekey_due = tick && (rekey_cnt == 16'h0000);
   wire tamper = (sup_level_i == door_pkg::SUP_OPEN) || (sup_level_i == door_pkg::SUP_SHORT);
   wire wiegand_fit = (wiegand_count_i == wiegand_len);

   // Entry event: suppressed when the grant lapses unused and suppression is on.
   wire grant_event = request && !suppress;
   wire passage_event = suppress && (state == door_pkg::ST_RELEASED) && any_open;
   wire any_event = grant_event || passage_event || card_denied;

   wire [15:0] set_mask = {6'h00,
                           card_denied,
                           tamper,
                           rekey_due,
                           new_serial,
                           subst,
                           bio_loss,
                           link_bad,
                           held_alarm,
                           forced,
                           any_event};

   // Timebase divider shared by every duration.
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
         div_cnt <= 16'h0000;
      else if (div_cnt >= tick_div)
         div_cnt <= 16'h0000;
      else
         div_cnt <= div_cnt + 16'h0001;
   end
   assign tick = (div_cnt >= tick_div);

   // Door sequencing.
   always_comb
   begin
      next_state = state;
      case (state)
         door_pkg::ST_LOCKED:
            if (request)
               next_state = door_pkg::ST_RELEASED;
            else if (any_open || any_unlocked)
               next_state = door_pkg::ST_HELD;
         door_pkg::ST_RELEASED:
            if (any_open)
               next_state = door_pkg::ST_OPEN;
            else if (tick && cnt_zero)
               next_state = door_pkg::ST_LOCKED;
         door_pkg::ST_OPEN:
            if (!any_open)
               next_state = door_pkg::ST_LOCKED;
            else if (tick && cnt_zero)
               next_state = door_pkg::ST_HELD;
         door_pkg::ST_HELD:
            if (!any_open && !any_unlocked)
               next_state = door_pkg::ST_LOCKED;
         default:
            next_state = door_pkg::ST_LOCKED;
      endcase
   end

   // Selects the count loaded on each state entry.
   wire [15:0] grant_time = extended ? ext_unlock_t : unlock_t;
   wire [15:0] release_time = suppress ? resecure_t : grant_time;
   wire entering = (next_state != state);
   wire [15:0] load_val = (next_state == door_pkg::ST_RELEASED) ? release_time :
                          (next_state == door_pkg::ST_OPEN) ? grant_time : held_t;

   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         state <= door_pkg::ST_LOCKED;
         door_cnt <= 16'h0000;
      end
      else
      begin
         state <= next_state;
         if (entering)
            door_cnt <= load_val;
         else if (tick && !cnt_zero)
            door_cnt <= door_cnt - 16'h0001;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
         lock_release_o <= 1'b0;
      else
         lock_release_o <= (next_state == door_pkg::ST_RELEASED) || (next_state == door_pkg::ST_OPEN);
   end

   // Event record toward the log.
   wire [3:0] ev_src = card_denied ? door_pkg::EV_DENIED :
                       exit_push_button_i ? door_pkg::EV_EXIT_BTN :
                       break_glass_unit_i ? door_pkg::EV_BREAK_GLASS : door_pkg::EV_CARD;
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
         event_o <= '0;
      else
         event_o <= '{valid: any_event, source: ev_src, zone: door_zone_i};
   end

   // Pending flags: a new event wins over an acknowledge in the same cycle.
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
         pending <= 16'h0000;
      else
         pending <= (pending & ~ack_mask) | set_mask;
   end

   // Alarm-linked relays, one per alarm input.
   // Each relay keeps its own flip-flops so that no vector is written from two processes.
   genvar gi;
   generate
      for (gi = 0; gi < NUM_RELAYS_L; gi = gi + 1)
      begin : g_relay
         wire [1:0] mode = relay_mode[2 * gi +: 2];
         wire rise = alarm_in_i[gi] && !alarm_q[gi];
         wire acked = ack_mask[door_pkg::PEND_W - NUM_RELAYS_L + gi];
         logic relay_on;
         logic [15:0] pulse_left;
         always_ff @(posedge clk_i)
         begin
            if (!resetn_i)
            begin
               relay_on <= 1'b0;
               pulse_left <= 16'h0000;
            end
            else
            begin
               case (mode)
                  door_pkg::MODE_LATCH:
                     relay_on <= rise || (relay_on && !acked);
                  door_pkg::MODE_PULSE:
                     if (rise)
                     begin
                        relay_on <= 1'b1;
                        pulse_left <= pulse_t;
                     end
                     else if (tick && relay_on)
                     begin
                        if (pulse_left <= 16'h0001)
                           relay_on <= 1'b0;
                        pulse_left <= pulse_left - 16'h0001;
                     end
                  door_pkg::MODE_FOLLOW:
                     relay_on <= alarm_in_i[gi];
                  default:
                     relay_on <= 1'b0;
               endcase
            end
         end
         assign relay_q[gi] = relay_on;
      end
   endgenerate

   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         alarm_q <= 4'h0;
         bio_q <= 1'b0;
         sched_relay_o <= 4'h0;
         sup_class_o <= door_pkg::SUP_NORMAL;
         wiegand_ok_o <= 1'b0;
      end
      else
      begin
         alarm_q <= alarm_in_i;
         bio_q <= bio_link_up_i;
         sched_relay_o <= sched_active_i & ctrl[door_pkg::CTRL_SCHED_LSB +: 4];
         sup_class_o <= sup_level_i;
         wiegand_ok_o <= wiegand_done_i && wiegand_fit && (wiegand_len <= door_pkg::WIEGAND_MAX_BITS);
      end
   end
   assign relay_o = relay_q;

   // Rekey interval counter in ticks, reloaded on expiry.
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
         rekey_cnt <= door_pkg::REKEY_RST;
      else if (rekey_due)
         rekey_cnt <= rekey_t;
      else if (tick)
         rekey_cnt <= rekey_cnt - 16'h0001;
   end

   // Serial binding for the assigned device.
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         serial_bound <= 32'h00000000;
         serial_known <= 1'b0;
      end
      else if (wr_i && addr_i == door_pkg::REG_SERIAL)
      begin
         serial_bound <= wdata_i;
         serial_known <= 1'b1;
      end
      else if (new_serial)
      begin
         serial_bound <= link_msg_i.serial;
         serial_known <= 1'b1;
      end
   end

   // Configuration registers.
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         tick_div <= door_pkg::TICK_DIV_RST;
         unlock_t <= door_pkg::UNLOCK_RST;
         ext_unlock_t <= door_pkg::EXT_UNLOCK_RST;
         held_t <= door_pkg::HELD_RST;
         resecure_t <= door_pkg::RESECURE_RST;
         pulse_t <= door_pkg::PULSE_RST;
         relay_mode <= 8'h00;
         ctrl <= 32'h00000000;
         wiegand_len <= door_pkg::WIEGAND_LEN_RST;
         rekey_t <= door_pkg::REKEY_RST;
      end
      else if (wr_i)
      begin
         case (addr_i)
            door_pkg::REG_TICK_DIV: tick_div <= wdata_i[15:0];
            door_pkg::REG_UNLOCK: unlock_t <= wdata_i[15:0];
            door_pkg::REG_EXT_UNLOCK: ext_unlock_t <= wdata_i[15:0];
            door_pkg::REG_HELD: held_t <= wdata_i[15:0];
            door_pkg::REG_RESECURE: resecure_t <= wdata_i[15:0];
            door_pkg::REG_PULSE: pulse_t <= wdata_i[15:0];
            door_pkg::REG_RELAY_MODE: relay_mode <= wdata_i[7:0];
            door_pkg::REG_CTRL: ctrl <= wdata_i;
            door_pkg::REG_WIEGAND_LEN: wiegand_len <= wdata_i[15:0];
            door_pkg::REG_REKEY: rekey_t <= wdata_i[15:0];
            default: ctrl <= ctrl;
         endcase
      end
   end

   // Read mux; unmapped addresses read zero.
   wire [31:0] status_word = {16'h0000, relay_q, sched_relay_o, sup_class_o, lockdown,
                              lock_release_o, state};
   wire [31:0] rd_mux = (addr_i == door_pkg::REG_TICK_DIV) ? {16'h0000, tick_div} :
                        (addr_i == door_pkg::REG_UNLOCK) ? {16'h0000, unlock_t} :
                        (addr_i == door_pkg::REG_EXT_UNLOCK) ? {16'h0000, ext_unlock_t} :
                        (addr_i == door_pkg::REG_HELD) ? {16'h0000, held_t} :
                        (addr_i == door_pkg::REG_RESECURE) ? {16'h0000, resecure_t} :
                        (addr_i == door_pkg::REG_PULSE) ? {16'h0000, pulse_t} :
                        (addr_i == door_pkg::REG_RELAY_MODE) ? {24'h000000, relay_mode} :
                        (addr_i == door_pkg::REG_CTRL) ? ctrl :
                        (addr_i == door_pkg::REG_PENDING) ? {16'h0000, pending} :
                        (addr_i == door_pkg::REG_STATUS) ? status_word :
                        (addr_i == door_pkg::REG_SERIAL) ? serial_bound :
                        (addr_i == door_pkg::REG_WIEGAND_LEN) ? {16'h0000, wiegand_len} :
                        (addr_i == door_pkg::REG_REKEY) ? {16'h0000, rekey_t} : 32'h00000000;

   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
         rdata_o <= 32'h00000000;
      else if (rd_i)
         rdata_o <= rd_mux;
      else
         rdata_o <= 32'h00000000;
   end
endmodule
`default_nettype wire

// [bench/door_chk.sv]
// Port-level assertions for the door access controller.
`timescale 1ns/10ps
`default_nettype none
module door_chk (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire door_pkg::grant_req_t card_grant_i,
   input wire logic exit_push_button_i,
   input wire logic break_glass_unit_i,
   input wire logic door_open_i,
   input wire logic leaf2_open_i,
   input wire logic [1:0] sup_level_i,
   input wire logic [3:0] sched_active_i,
   input wire logic wiegand_done_i,
   input wire logic lock_release_o,
   input wire logic [3:0] relay_o,
   input wire logic [3:0] sched_relay_o,
   input wire door_pkg::event_rec_t event_o,
   input wire logic wiegand_ok_o,
   input wire logic [1:0] sup_class_o
);
   default clocking @(posedge clk_i);
   endclocking
   reset_quiet_a: assert property (!resetn_i |=> !lock_release_o && relay_o == 4'h0 && !event_o.valid)
      else $error("output active after reset");
   sup_copy_a: assert property (disable iff (!resetn_i) 1'b1 |=> sup_class_o == $past(sup_level_i))
      else $error("supervised class does not follow its input");
   exit_event_a: assert property (disable iff (!resetn_i)
      exit_push_button_i && !card_grant_i.valid && !break_glass_unit_i
      |=> event_o.valid && event_o.source == door_pkg::EV_EXIT_BTN)
      else $error("exit button press not recorded");
   glass_event_a: assert property (disable iff (!resetn_i)
      break_glass_unit_i && !card_grant_i.valid && !exit_push_button_i
      |=> event_o.valid && event_o.source == door_pkg::EV_BREAK_GLASS)
      else $error("break glass not recorded");
   exit_release_a: assert property (disable iff (!resetn_i) exit_push_button_i |=> lock_release_o)
      else $error("exit request did not release the lock");
   no_free_release_a: assert property (disable iff (!resetn_i) $rose(lock_release_o)
      |-> $past(exit_push_button_i) || $past(break_glass_unit_i) || $past(card_grant_i.valid))
      else $error("lock released without a request");
   close_relock_a: assert property (disable iff (!resetn_i)
      lock_release_o && $fell(door_open_i) && !leaf2_open_i && !exit_push_button_i
      && !break_glass_unit_i && !card_grant_i.valid |=> !lock_release_o)
      else $error("no relock after the door closed");
   wiegand_cause_a: assert property (disable iff (!resetn_i) wiegand_ok_o |-> $past(wiegand_done_i))
      else $error("card frame accepted without a frame");
   sched_cause_a: assert property (disable iff (!resetn_i) (sched_relay_o & ~$past(sched_active_i)) == 4'h0)
      else $error("schedule relay on without its schedule");
endmodule
bind door_access_controller door_chk chk_u (.clk_i, .resetn_i, .card_grant_i, .exit_push_button_i,
   .break_glass_unit_i, .door_open_i, .leaf2_open_i, .sup_level_i, .sched_active_i, .wiegand_done_i,
   .lock_release_o, .relay_o, .sched_relay_o, .event_o, .wiegand_ok_o, .sup_class_o);
`default_nettype wire

// [bench/door_model.sv]
// Behavioural door leaf and lock on the far side of the controller.
`timescale 1ns/10ps
`default_nettype none
module door_model (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic release_i,
   input wire logic pass_i,
   input wire logic hold_i,
   input wire logic force_i,
   output logic open_o,
   output logic unlocked_o
);
   logic [1:0] left;
   // The lock follows its drive at once; a lagging lock would look forced to the controller.
   assign unlocked_o = release_i;
   // A user only passes a released door and needs a few cycles to get through.
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         open_o <= 1'b0;
         left <= 2'h0;
      end
      else if (pass_i && unlocked_o)
      begin
         open_o <= 1'b1;
         left <= 2'h3;
      end
      else if (left != 2'h0)
         left <= left - 2'h1;
      else
         open_o <= force_i || (hold_i && open_o);
   end
endmodule
`default_nettype wire

// [bench/tb.sv]
// Self-checking bench for the door access controller.
`timescale 1ns/10ps
`default_nettype none
module tb;
   localparam logic [7:0] ZONE = 8'h05;
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   door_pkg::grant_req_t grant = '0;
   door_pkg::link_msg_t link = '0;
   logic btn = 1'b0, glass = 1'b0, leaf2 = 1'b0, bio = 1'b1, wdone = 1'b0;
   logic pass = 1'b0, hold = 1'b0, forced = 1'b0;
   logic leaf2u = 1'b0;
   logic [1:0] sup = 2'h0;
   logic [3:0] alarm = 4'h0;
   logic [3:0] sched = 4'hF;
   logic [15:0] wcnt = 16'h0;
   logic [31:0] rdata, rv;
   logic opened, release_lock, wok;
   logic [3:0] relay, srelay;
   logic [1:0] sclass;
   door_pkg::event_rec_t ev;
   int bad_count = 0;
   int checks_done = 0;
   int cycles = 0;
   logic [7:0] ra [9] = '{door_pkg::REG_TICK_DIV, door_pkg::REG_UNLOCK, door_pkg::REG_EXT_UNLOCK,
      door_pkg::REG_HELD, door_pkg::REG_RESECURE, door_pkg::REG_PULSE, door_pkg::REG_WIEGAND_LEN,
      door_pkg::REG_REKEY, 8'h3F};
   logic [15:0] rx [9] = '{door_pkg::TICK_DIV_RST, door_pkg::UNLOCK_RST, door_pkg::EXT_UNLOCK_RST,
      door_pkg::HELD_RST, door_pkg::RESECURE_RST, door_pkg::PULSE_RST, door_pkg::WIEGAND_LEN_RST,
      door_pkg::REKEY_RST, 16'h0};
   always #2.5 clk_i = ~clk_i;
   door_model model_u (.clk_i(clk_i), .resetn_i(resetn_i), .release_i(release_lock), .pass_i(pass),
      .hold_i(hold), .force_i(forced), .open_o(opened), .unlocked_o());
   door_access_controller dut (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .card_grant_i(grant), .exit_push_button_i(btn),
      .break_glass_unit_i(glass), .door_open_i(opened), .door_unlocked_i(release_lock),
      .leaf2_open_i(leaf2), .leaf2_unlocked_i(leaf2u), .door_zone_i(ZONE), .sup_level_i(sup),
      .alarm_in_i(alarm), .sched_active_i(sched), .link_msg_i(link), .bio_link_up_i(bio),
      .wiegand_done_i(wdone), .wiegand_count_i(wcnt), .lock_release_o(release_lock), .relay_o(relay),
      .sched_relay_o(srelay), .event_o(ev), .wiegand_ok_o(wok), .sup_class_o(sclass));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_i);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a);
      @(posedge clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      #1 rv = rdata;
   endtask
   task automatic pend(input int b, input logic e);
      rd_reg(door_pkg::REG_PENDING);
      chk(32'(rv[b]), 32'(e));
   endtask
   task automatic req(input int k);
      @(posedge clk_i);
      case (k)
         0: btn <= 1'b1;
         1: glass <= 1'b1;
         default: grant <= '{1'b1, k == 3, ZONE};
      endcase
      @(posedge clk_i);
      btn <= 1'b0;
      glass <= 1'b0;
      grant <= '0;
      #1;
   endtask
   task automatic lnk(input logic ok, input logic [31:0] s);
      @(posedge clk_i);
      link <= '{1'b1, ok, s[3:0], s};
      @(posedge clk_i);
      link <= '0;
   endtask
   task automatic end_sim;
      $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Bounds a hang; the whole sequence needs well under a thousand cycles.
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         bad_count++;
         end_sim;
      end
   end
   initial
   begin
      repeat (6) @(posedge clk_i);
      resetn_i <= 1'b1;
      chk(32'({release_lock, relay, ev}), 32'h0);
      for (int i = 0; i < 9; i++)
      begin
         rd_reg(ra[i]);
         chk(rv, 32'(rx[i]));
      end
      wr_reg(door_pkg::REG_TICK_DIV, 32'h0);
      wr_reg(door_pkg::REG_REKEY, 32'h20);
      wr_reg(door_pkg::REG_UNLOCK, 32'h1E);
      wr_reg(door_pkg::REG_EXT_UNLOCK, 32'h30);
      wr_reg(door_pkg::REG_HELD, 32'h6);
      req(0);
      chk(32'({release_lock, ev}), 32'({2'h3, door_pkg::EV_EXIT_BTN, ZONE}));
      cyc(24);
      chk(32'(release_lock), 32'h1);
      cyc(10);
      chk(32'(release_lock), 32'h0);
      req(3);
      chk(32'(ev), 32'({1'b1, door_pkg::EV_CARD, ZONE}));
      cyc(40);
      chk(32'(release_lock), 32'h1);
      cyc(14);
      chk(32'(release_lock), 32'h0);
      req(1);
      @(posedge clk_i);
      pass <= 1'b1;
      @(posedge clk_i);
      pass <= 1'b0;
      cyc(2);
      chk(32'(opened), 32'h1);
      cyc(6);
      chk(32'({opened, release_lock}), 32'h0);
      for (int j = 0; j < 3; j++)
      begin
         wr_reg(door_pkg::REG_PENDING, 32'h3FF);
         pend(1, 1'b0);
         @(posedge clk_i);
         forced <= (j == 0);
         leaf2 <= (j == 1);
         leaf2u <= (j == 2);
         repeat (3) @(posedge clk_i);
         forced <= 1'b0;
         leaf2 <= 1'b0;
         leaf2u <= 1'b0;
         pend(1, 1'b1);
      end
      cyc(2);
      wr_reg(door_pkg::REG_PENDING, 32'h3FF);
      pend(1, 1'b0);
      req(0);
      @(posedge clk_i);
      pass <= 1'b1;
      hold <= 1'b1;
      @(posedge clk_i);
      pass <= 1'b0;
      cyc(45);
      pend(2, 1'b1);
      @(posedge clk_i);
      hold <= 1'b0;
      cyc(8);
      wr_reg(door_pkg::REG_RELAY_MODE, 32'h39);
      @(posedge clk_i);
      alarm <= 4'hF;
      cyc(2);
      chk(32'(relay), 32'h7);
      @(posedge clk_i);
      alarm <= 4'h0;
      cyc(6);
      chk(32'(relay), 32'h1);
      wr_reg(door_pkg::REG_PENDING, 32'h1000);
      cyc(2);
      chk(32'(relay), 32'h0);
      wr_reg(door_pkg::REG_CTRL, 32'hA00);
      cyc(2);
      chk(32'(srelay), 32'hA);
      wr_reg(door_pkg::REG_CTRL, 32'h2);
      req(2);
      chk(32'({release_lock, ev}), 32'({2'h1, door_pkg::EV_DENIED, ZONE}));
      chk(32'(srelay), 32'h0);
      wr_reg(door_pkg::REG_CTRL, 32'h10000);
      wr_reg(door_pkg::REG_PENDING, 32'h3FF);
      req(0);
      cyc(35);
      req(2);
      chk(32'({release_lock, ev}), 32'({2'h1, door_pkg::EV_DENIED, ZONE}));
      wr_reg(door_pkg::REG_CTRL, 32'h1);
      wr_reg(door_pkg::REG_PENDING, 32'h3FF);
      req(2);
      chk(32'({release_lock, ev.valid}), 32'h2);
      cyc(14);
      chk(32'(release_lock), 32'h0);
      wr_reg(door_pkg::REG_CTRL, 32'h0);
      lnk(1'b0, 32'h1234);
      pend(3, 1'b1);
      lnk(1'b1, 32'hA5);
      pend(6, 1'b1);
      pend(5, 1'b0);
      lnk(1'b1, 32'hB6);
      pend(5, 1'b1);
      rd_reg(door_pkg::REG_SERIAL);
      chk(rv, 32'hA5);
      @(posedge clk_i);
      bio <= 1'b0;
      cyc(2);
      pend(4, 1'b1);
      @(posedge clk_i);
      bio <= 1'b1;
      req(0);
      chk(32'(release_lock), 32'h1);
      wr_reg(door_pkg::REG_PENDING, 32'h3FF);
      cyc(40);
      pend(7, 1'b1);
      lnk(1'b1, 32'h000000AC);
      pend(3, 1'b1);
      pend(5, 1'b0);
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clk_i);
         sup <= 2'(i);
         wdone <= (i < 2);
         wcnt <= 16'h001A - 16'(i);
         @(posedge clk_i);
         wdone <= 1'b0;
         #1;
         chk(32'({sclass, wok}), 32'({2'(i), i == 0}));
      end
      @(posedge clk_i);
      alarm <= 4'h1;
      repeat (3) @(posedge clk_i);
      alarm <= 4'h0;
      resetn_i <= 1'b0;
      cyc(6);
      chk(32'({release_lock, relay}), 32'h0);
      @(posedge clk_i);
      resetn_i <= 1'b1;
      rd_reg(door_pkg::REG_UNLOCK);
      chk(rv, 32'(door_pkg::UNLOCK_RST));
      end_sim;
   end
endmodule
`default_nettype wire
